//--- jla_link_align.sv
`timescale 1ns/1ps
// Function
// - Frame and multiframe clocks internal, phase lane
// - Frame timing configured same at both ends
// - Clocks start at default phase after reset
// - Sysref edges count only with gate open
// - Power-down stops clocks and drops link
// - Divider change stops clocks, breaks link
// - Sync request restarts link initialisation
// - Misaligned sysref edge realigns, breaks link
// - Aligned sysref edge changes nothing
// - Sample clock loss breaks the link
// - Alignment sequence carries link parameters
// - Optional scrambling of lane data
// - Low sync level is an active request
// - Sync select one takes register sync bit
module jla_link_align #(
  parameter int DW     = 16,                    // Sample width
  parameter int BUF_AW = 1                      // Buffer index width, two entries
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sysref,
  input  wire logic              sync_n,
  input  wire logic              sample_clock_lost,
  input  wire logic [DW-1:0]     smp_data,
  input  wire logic              smp_valid,
  output logic                   smp_ready,
  output jla_pkg::jla_lane_s     lane_out,
  output logic                   lane_stb,
  output logic                   link_up
);
  import jla_pkg::*;

  localparam int DEPTH = 1 << BUF_AW;           // Buffer entries

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Known register offsets
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_FRAME) || (a == OFS_ILAS) || (a == OFS_STATUS);
  endfunction : mapped

  // Last divider phase for ratios 1, 2, 4, 8
  function automatic logic [2:0] div_last(input logic [1:0] d);
    div_last = 3'((4'h1 << d) - 4'h1);
  endfunction : div_last

  // Self-synchronising scrambler, 1 + x^14 + x^15, MSB first
  function automatic logic [30:0] scramble(input logic [14:0] s, input logic [15:0] d);
    logic [14:0] st;
    logic [15:0] o;
    logic        b;
    st = s;
    o  = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      b    = d[i] ^ st[14] ^ st[13];
      o[i] = b;
      st   = {st[13:0], b};
    end
    scramble = {st, o};
  endfunction : scramble

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  jla_ctrl_s      ctrl_q;                       // Control word
  logic [4:0]     kmax_q;                       // K minus one
  logic [7:0]     dev_id_q;                     // Identity octet
  logic [4:0]     lane_id_q;                    // Identity octet
  logic           realigned_q;                  // Sticky realign flag
  logic           broken_q;                     // Sticky break flag
  logic           div_chg_q;                    // One cycle after a divider change
  logic [31:0]    prdata_q;                     // Read data
  logic           pslverr_q;                    // Unmapped access
  logic [2:0]     div_ctr_q;                    // Divider phase
  logic [4:0]     lmfc_q;                       // Frame index in multiframe
  logic           sr_prev_q;                    // Gated sysref, last cycle
  jla_link_e      state_q;                      // Link state
  logic [1:0]     mf_q;                         // Alignment multiframe count
  logic [14:0]    scr_q;                        // Scrambler state
  jla_lane_s      lane_q;                       // Lane word
  logic           lane_stb_q;                   // Lane word strobe
  logic [DW-1:0]  mem_q [DEPTH];                // Buffer storage
  logic [BUF_AW:0] wr_ptr_q;                    // Buffer write pointer
  logic [BUF_AW:0] rd_ptr_q;                    // Buffer read pointer

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  logic wr_en;                                  // Write takes effect
  logic rd_setup;                               // Read data captured
  logic wr_ctrl;                                // Control written
  logic clr_stat;                               // Status written
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign wr_ctrl  = wr_en && paddr == OFS_CTRL;
  assign clr_stat = wr_en && paddr == OFS_STATUS;
  assign pready   = penable;
  assign prdata   = prdata_q;
  assign pslverr  = pslverr_q & penable;

  // Control and configuration writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q    <= '0;
      kmax_q    <= KMAX_RST;
      dev_id_q  <= DEV_ID_RST;
      lane_id_q <= LANE_ID_RST;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL) begin
        ctrl_q <= '{div: pwdata[CTRL_DIV_LSB+:2], pdn: pwdata[CTRL_PDN],
                    sync_reg: pwdata[CTRL_SYNC_REG], sync_sel: pwdata[CTRL_SYNC_SEL],
                    scr_en: pwdata[CTRL_SCR], gate_en: pwdata[CTRL_GATE]};
      end
      if (paddr == OFS_FRAME) begin
        kmax_q <= pwdata[4:0];
      end
      if (paddr == OFS_ILAS) begin
        dev_id_q  <= pwdata[7:0];
        lane_id_q <= pwdata[12:8];
      end
    end
  end

  // Divider change marker
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_chg_q <= 1'b0;
    end else begin
      div_chg_q <= wr_ctrl && pwdata[CTRL_DIV_LSB+:2] != ctrl_q.div;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (rd_setup) begin
      pslverr_q <= ~mapped(paddr);
      unique case (paddr)
        OFS_CTRL:   prdata_q <= {22'h0, ctrl_q.div, 3'h0, ctrl_q.pdn, ctrl_q.sync_reg,
                                 ctrl_q.sync_sel, ctrl_q.scr_en, ctrl_q.gate_en};
        OFS_FRAME:  prdata_q <= {27'h0, kmax_q};
        OFS_ILAS:   prdata_q <= {19'h0, lane_id_q, dev_id_q};
        OFS_STATUS: prdata_q <= {19'h0, lmfc_q, 2'h0, broken_q, realigned_q, 2'h0, state_q};
        default:    prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Frame and multiframe clocks
  // ----------------------------------------------------------------
  logic       clk_run;                          // Internal clocks running
  logic       frame_tick;                       // Last cycle of a frame
  logic       lmfc_last;                        // Last cycle of a multiframe
  logic       sr_edge;                          // Gated sysref rising edge
  logic       realign;                          // Misaligned edge
  logic       sync_req;                         // Receiver wants resync
  logic       link_brk;                         // Realign, divider change or clock loss
  assign clk_run    = ~ctrl_q.pdn & ~sample_clock_lost & ~div_chg_q;
  assign frame_tick = clk_run && div_ctr_q == div_last(ctrl_q.div);
  assign lmfc_last  = frame_tick && lmfc_q == kmax_q;
  assign sr_edge    = ctrl_q.gate_en & sysref & ~sr_prev_q;
  assign realign    = sr_edge & clk_run & ~lmfc_last;
  assign sync_req   = ctrl_q.sync_sel ? ctrl_q.sync_reg : ~sync_n;
  assign link_brk   = realign | div_chg_q | sample_clock_lost;

  // Sysref sampler, cleared while the gate is shut
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sr_prev_q <= 1'b0;
    end else begin
      sr_prev_q <= ctrl_q.gate_en & sysref;
    end
  end

  // Divider phase and frame index
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_ctr_q <= 3'h0;
      lmfc_q    <= 5'h00;
    end else if (!clk_run || realign) begin
      div_ctr_q <= 3'h0;
      lmfc_q    <= 5'h00;
    end else if (frame_tick) begin
      div_ctr_q <= 3'h0;
      lmfc_q    <= (lmfc_q == kmax_q) ? 5'h00 : 5'(lmfc_q + 5'h01);
    end else begin
      div_ctr_q <= 3'(div_ctr_q + 3'h1);
    end
  end

  // ----------------------------------------------------------------
  // Link state
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= JLA_OFF;
    end else if (ctrl_q.pdn) begin
      state_q <= JLA_OFF;
    end else begin
      unique case (state_q)
        JLA_OFF:  state_q <= JLA_CGS;
        JLA_CGS:  if (!link_brk && !sync_req && lmfc_last) begin
                    state_q <= JLA_ILAS;
                  end
        JLA_ILAS: if (link_brk || sync_req) begin
                    state_q <= JLA_CGS;
                  end else if (lmfc_last && mf_q == ILAS_LAST_MF) begin
                    state_q <= JLA_DATA;
                  end
        JLA_DATA: if (link_brk || sync_req) begin
                    state_q <= JLA_CGS;
                  end
      endcase
    end
  end

  // Alignment multiframe counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mf_q <= 2'h0;
    end else if (state_q != JLA_ILAS) begin
      mf_q <= 2'h0;
    end else if (lmfc_last) begin
      mf_q <= 2'(mf_q + 2'h1);
    end
  end

  // Sticky flags, a new event wins over a clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      realigned_q <= 1'b0;
      broken_q    <= 1'b0;
    end else begin
      realigned_q <= realign | (realigned_q & ~(clr_stat & pwdata[STAT_REALIGN]));
      broken_q    <= ((state_q inside {JLA_ILAS, JLA_DATA}) & (link_brk | sync_req | ctrl_q.pdn))
                     | (broken_q & ~(clr_stat & pwdata[STAT_BROKEN]));
    end
  end

  // ----------------------------------------------------------------
  // Two-entry sample buffer
  // ----------------------------------------------------------------
  logic          buf_full;                      // No room
  logic          buf_valid;                     // Head present
  logic          push;                          // Sample accepted
  logic          pop;                           // Sample sent on the lane
  logic [DW-1:0] head;                          // Oldest sample
  assign buf_full  = (wr_ptr_q ^ rd_ptr_q) == {1'b1, {BUF_AW{1'b0}}};
  assign buf_valid = wr_ptr_q != rd_ptr_q;
  assign smp_ready = ~buf_full;
  assign push      = smp_valid & ~buf_full;
  assign pop       = frame_tick && state_q == JLA_DATA && buf_valid;
  assign head      = mem_q[rd_ptr_q[BUF_AW-1:0]];

  // Pointers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  // Storage, written at the write index
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q[BUF_AW-1:0]] <= smp_data;
    end
  end

  // ----------------------------------------------------------------
  // Lane word builder
  // ----------------------------------------------------------------
  // Link parameter octets, in transmit order
  function automatic logic [7:0] prm(input logic [2:0] i);
    logic [7:0] v;
    v = 8'h00;
    unique case (i)
      3'h0: v = dev_id_q;
      3'h1: v = {3'h0, lane_id_q};
      3'h2: v = {ctrl_q.scr_en, 7'h00};
      3'h3: v = PRM_F_M1;
      3'h4: v = {3'h0, kmax_q};
      3'h5: v = PRM_N_M1;
      3'h6: v = PRM_NP_M1;
      3'h7: v = PRM_CS ^ PRM_VER;
    endcase
    prm = v;
  endfunction : prm

  jla_lane_s   nxt;                             // Word for this frame
  logic [30:0] scr_res;                         // Scrambler result
  logic [15:0] raw;                             // Sample or underrun zero
  logic [2:0]  pi;                              // Parameter pair index
  assign raw     = buf_valid ? 16'(head) : 16'h0000;
  assign scr_res = scramble(scr_q, raw);
  assign pi      = 3'(lmfc_q - 5'h02);

  always_comb begin
    nxt = '{data: {CH_K, CH_K}, ctrl: 2'b11}; // Sync characters
    unique case (state_q)
      JLA_OFF:  nxt = '{data: 16'h0000, ctrl: 2'b00};
      JLA_CGS:  nxt = '{data: {CH_K, CH_K}, ctrl: 2'b11};
      JLA_ILAS: begin
        nxt = '{data: {3'h0, lmfc_q, 3'h0, lmfc_q}, ctrl: 2'b00};
        if (mf_q == 2'h1 && lmfc_q == 5'h01) begin
          nxt = '{data: {CH_Q, 8'h00}, ctrl: 2'b10};
        end else if (mf_q == 2'h1 && lmfc_q >= 5'h02 && lmfc_q <= 5'h05) begin
          nxt = '{data: {prm({pi[1:0], 1'b0}), prm({pi[1:0], 1'b1})}, ctrl: 2'b00};
        end
        if (lmfc_q == 5'h00) begin
          nxt.data[15:8] = CH_R;
          nxt.ctrl[1]    = 1'b1;
        end
        if (lmfc_q == kmax_q) begin
          nxt.data[7:0] = CH_A;
          nxt.ctrl[0]   = 1'b1;
        end
      end
      JLA_DATA: nxt = '{data: ctrl_q.scr_en ? scr_res[15:0] : raw, ctrl: 2'b00};
    endcase
  end

  // Lane register, loaded once per frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lane_q     <= '0;
      lane_stb_q <= 1'b0;
    end else begin
      lane_stb_q <= frame_tick && state_q != JLA_OFF;
      if (frame_tick) begin
        lane_q <= nxt;
      end
    end
  end

  // Scrambler state advances once per frame in the data state, underrun zeros included
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scr_q <= SCR_SEED;
    end else if (state_q != JLA_DATA) begin
      scr_q <= SCR_SEED;
    end else if (frame_tick && ctrl_q.scr_en) begin
      scr_q <= scr_res[30:16];
    end
  end

  assign lane_out = lane_q;
  assign lane_stb = lane_stb_q;
  assign link_up  = state_q == JLA_DATA;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_gate_closed: assert property (!ctrl_q.gate_en |=> !$rose(realigned_q))
    else $error("sysref acted with gate closed");
  chk_realign_zero: assert property (realign && state_q == JLA_DATA && !ctrl_q.pdn
    |=> div_ctr_q == 3'h0 && lmfc_q == 5'h00 && state_q == JLA_CGS)
    else $error("misaligned sysref did not realign");
  chk_aligned_keep: assert property (sr_edge && lmfc_last && state_q == JLA_DATA
    && !sync_req && !sample_clock_lost && !div_chg_q && !ctrl_q.pdn |=> state_q == JLA_DATA && lmfc_q == 5'h00)
    else $error("aligned sysref disturbed link");
  chk_pdn_stops: assert property (ctrl_q.pdn ##1 ctrl_q.pdn |-> state_q == JLA_OFF
    && lmfc_q == 5'h00 && !frame_tick)
    else $error("power-down left clocks running");
  chk_div_break: assert property (div_chg_q && !ctrl_q.pdn |=> state_q == JLA_CGS)
    else $error("divider change kept link");
  chk_sync_drop: assert property (sync_req && state_q == JLA_DATA && !ctrl_q.pdn
    |=> state_q == JLA_CGS ##[1:9] lane_stb && lane_out.ctrl == 2'b11)
    else $error("sync request did not restart link");
  chk_clock_loss: assert property (sample_clock_lost && !ctrl_q.pdn |=> state_q == JLA_CGS
    && lmfc_q == 5'h00)
    else $error("sample clock loss kept link");
  chk_lmfc_step: assert property (frame_tick && lmfc_q != kmax_q && !realign
    |=> lmfc_q == $past(lmfc_q) + 5'h01)
    else $error("multiframe index did not step");
  chk_sync_select: assert property (ctrl_q.sync_sel && !ctrl_q.sync_reg && !link_brk
    && state_q == JLA_DATA && !ctrl_q.pdn |=> state_q == JLA_DATA)
    else $error("pin sync acted while register selected");
  chk_plain_data: assert property (pop && !ctrl_q.scr_en |=> lane_out.data == $past(raw)
    && lane_stb && lane_out.ctrl == 2'b00)
    else $error("unscrambled sample altered");

endmodule : jla_link_align

//--- jla_pkg.sv
package jla_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL   = 8'h00;   // Control word
  localparam logic [7:0]  OFS_FRAME  = 8'h04;   // Frames per multiframe minus one
  localparam logic [7:0]  OFS_ILAS   = 8'h08;   // Identity octets sent in the alignment sequence
  localparam logic [7:0]  OFS_STATUS = 8'h0c;   // Link state and sticky flags

  // Control field positions
  localparam int CTRL_GATE     = 0;             // Sysref detection gate
  localparam int CTRL_SCR      = 1;             // Scrambling enable
  localparam int CTRL_SYNC_SEL = 2;             // Sync source: 1 = register bit
  localparam int CTRL_SYNC_REG = 3;             // Register sync request, 1 = request
  localparam int CTRL_PDN      = 4;             // Power-down / sleep
  localparam int CTRL_DIV_LSB  = 8;             // Divider select, two bits

  // Status field positions
  localparam int STAT_REALIGN  = 4;             // Sticky: clocks were realigned
  localparam int STAT_BROKEN   = 5;             // Sticky: a running link was dropped
  localparam int STAT_LMFC_LSB = 8;             // Live multiframe position

  // Values after reset
  localparam logic [4:0]  KMAX_RST   = 5'h13;   // K = 20
  localparam logic [7:0]  DEV_ID_RST = 8'h5a;   // Arbitrary identity value
  localparam logic [4:0]  LANE_ID_RST = 5'h00;  // Arbitrary identity value
  localparam logic [14:0] SCR_SEED   = 15'h7fff;

  // ----------------------------------------------------------------
  // Control characters and alignment sequence figures
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_K = 8'hbc;          // Group sync character
  localparam logic [7:0] CH_R = 8'h1c;          // Multiframe start
  localparam logic [7:0] CH_A = 8'h7c;          // Multiframe end
  localparam logic [7:0] CH_Q = 8'h9c;          // Link parameters follow
  localparam logic [1:0] ILAS_LAST_MF = 2'h3;   // Four multiframes
  localparam logic [7:0] PRM_F_M1  = 8'h01;     // Two octets per frame
  localparam logic [7:0] PRM_N_M1  = 8'h0d;     // 14-bit samples
  localparam logic [7:0] PRM_NP_M1 = 8'h2f;     // Subclass 1, 16-bit words
  localparam logic [7:0] PRM_CS    = 8'h02;     // Advertised control bits
  localparam logic [7:0] PRM_VER   = 8'h21;     // Version and lane count field

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    JLA_OFF  = 2'b00,                           // Clocks stopped
    JLA_CGS  = 2'b01,                           // Code group sync
    JLA_ILAS = 2'b10,                           // Lane alignment sequence
    JLA_DATA = 2'b11                            // Samples flowing
  } jla_link_e;

  typedef struct packed {
    logic [1:0] div;                            // Divider select
    logic       pdn;                            // Power-down
    logic       sync_reg;                       // Register sync request
    logic       sync_sel;                       // Sync source select
    logic       scr_en;                         // Scrambling
    logic       gate_en;                        // Sysref gate
  } jla_ctrl_s;

  typedef struct packed {
    logic [15:0] data;                          // Two octets, first in high byte
    logic [1:0]  ctrl;                          // Control flag per octet
  } jla_lane_s;

endpackage : jla_pkg

//--- jla_rx_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Receiver stand-in: sync requests, lane word capture
// ------------------------------------------------------------
module jla_rx_model (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               req,
  input  wire jla_pkg::jla_lane_s lane_out,
  input  wire logic               lane_stb,
  input  wire logic               link_up,
  output logic                    sync_n,
  output logic [15:0]             prm_w,
  output logic [15:0]             dat_w
);
  import jla_pkg::*;
  logic seen_q;                     // Last word was the parameter marker
  // Request is an active low level
  assign sync_n = ~req;
  // Keep word after marker; widths not trusted for data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seen_q <= 1'h0;
      prm_w  <= 16'h0;
      dat_w  <= 16'h0;
    end else if (lane_stb) begin
      seen_q <= (lane_out.data[15:8] == CH_Q) && (lane_out.ctrl == 2'h2);
      if (seen_q) prm_w <= lane_out.data;
      if (link_up && lane_out.ctrl == 2'h0 && lane_out.data != 16'h0) dat_w <= lane_out.data;
    end
  end
endmodule : jla_rx_model

//--- jla_link_align_tb_top.sv
`timescale 1ns/1ps
module jla_link_align_tb_top;
  import jla_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic er;} jla_row_s;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, sysref, sync_n;
  logic        smp_valid, smp_ready, sample_clock_lost, lane_stb, link_up, req, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] smp_data, prm_w, dat_w;
  jla_lane_s   lane_out;
  int          mismatches, n_tests, n, c;
  // Register table: reads and writes beside expected data and error
  jla_row_s rows [10] = '{'{1'h0, 8'h00, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h13, 1'h0},
    '{1'h0, 8'h08, 32'h0, 32'h5a, 1'h0}, '{1'h0, 8'h10, 32'h0, 32'h0, 1'h1},
    '{1'h1, 8'h04, 32'h5, 32'h0, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h5, 1'h0},
    '{1'h1, 8'h10, 32'hff, 32'h0, 1'h1}, '{1'h1, 8'h00, 32'h2, 32'h0, 1'h0},
    '{1'h0, 8'h00, 32'h0, 32'h2, 1'h0}, '{1'h1, 8'h00, 32'h0, 32'h0, 1'h0}};

  jla_link_align dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sysref(sysref),
    .sync_n(sync_n), .sample_clock_lost(sample_clock_lost), .smp_data(smp_data), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .lane_out(lane_out), .lane_stb(lane_stb), .link_up(link_up));
  jla_rx_model rx_u (.ref_clk(ref_clk), .rst(rst), .req(req), .lane_out(lane_out), .lane_stb(lane_stb),
    .link_up(link_up), .sync_n(sync_n), .prm_w(prm_w), .dat_w(dat_w));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  // One APB transfer, result in rd and er
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask : apb

  // Sysref edge, then low until g cycles after it
  task automatic pulse(input int g);
    sysref <= 1'h1;
    @(posedge ref_clk);
    sysref <= 1'h0;
    repeat (g - 1) @(posedge ref_clk);
  endtask : pulse

  task automatic wait_lu(input logic v);
    n = 0;
    while (link_up !== v && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, link_up}, {31'h0, v});
  endtask : wait_lu

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Hang guard
  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, req} = 2'h2;
    {psel, penable, pwrite, sysref, smp_valid, sample_clock_lost} = 6'h0;
    {paddr, pwdata, smp_data} = 56'h0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].e);
      chk({31'h0, er}, {31'h0, rows[i].er});
    end
    // Stalled link: buffer fills and refuses
    wait_lu(1'h1);
    req <= 1'h1;
    wait_lu(1'h0);
    smp_data  <= 16'h1234;
    smp_valid <= 1'h1;
    c = 0;
    repeat (4) begin
      @(posedge ref_clk);
      if (smp_ready === 1'h1) c++;
    end
    chk(c, 2);
    chk({31'h0, smp_ready}, 32'h0);
    req <= 1'h0;
    wait_lu(1'h1);
    repeat (20) @(posedge ref_clk);
    smp_valid <= 1'h0;
    repeat (10) @(posedge ref_clk);
    chk({16'h0, dat_w}, 32'h1234);
    chk({31'h0, smp_ready}, 32'h1);
    // Register sync source, then first scrambled sample after relink
    apb(1'h1, OFS_CTRL, 32'he);
    wait_lu(1'h0);
    smp_valid <= 1'h1;
    apb(1'h1, OFS_CTRL, 32'h6);
    smp_valid <= 1'h0;
    wait_lu(1'h1);
    do @(posedge ref_clk); while (lane_stb !== 1'h1);
    chk({16'h0, lane_out.data}, 32'h1236);
    req <= 1'h1;
    repeat (20) @(posedge ref_clk);
    chk({31'h0, link_up}, 32'h1);
    req <= 1'h0;
    // Gate closed: edges ignored
    apb(1'h1, OFS_CTRL, 32'h0);
    apb(1'h1, OFS_STATUS, 32'h30);
    pulse(3);
    pulse(3);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h0);
    // Gate open: misaligned edge, then periodic aligned edges
    apb(1'h1, OFS_CTRL, 32'h1);
    pulse(3);
    pulse(6);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h3);
    apb(1'h1, OFS_STATUS, 32'h30);
    repeat (6) @(posedge ref_clk);
    pulse(6);
    pulse(6);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h0);
    apb(1'h1, OFS_CTRL, 32'h0);
    // Divider change, clock loss, power-down
    wait_lu(1'h1);
    apb(1'h1, OFS_CTRL, 32'h100);
    wait_lu(1'h0);
    wait_lu(1'h1);
    sample_clock_lost <= 1'h1;
    wait_lu(1'h0);
    sample_clock_lost <= 1'h0;
    wait_lu(1'h1);
    apb(1'h1, OFS_CTRL, 32'h110);
    repeat (3) @(posedge ref_clk);
    c = 0;
    repeat (20) begin
      @(posedge ref_clk);
      if (lane_stb !== 1'h0) c++;
    end
    chk(c, 0);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h0);
    apb(1'h1, OFS_CTRL, 32'h100);
    wait_lu(1'h1);
    chk({16'h0, prm_w}, 32'h5a00);
    // Reset in mid-run: link down, defaults back
    rst <= 1'h1;
    @(posedge ref_clk);
    chk({31'h0, link_up}, 32'h0);
    rst <= 1'h0;
    apb(1'h0, OFS_FRAME, 32'h0);
    chk(rd, 32'h13);
    finish_test();
  end
endmodule : jla_link_align_tb_top
